// *** acs_pkg.sv ***
// Constants and types for the conversion sequencer
package acs_pkg;
	localparam int CLK_HZ = 40000000;
	localparam logic [3:0] NORMAL_CYCLES = 4'hD;
	localparam logic [4:0] FIRST_CYCLES = 5'h19;
	localparam logic [3:0] DIFF_SLOW_CYCLES = 4'hE;
	localparam logic [4:0] SAMPLE_NORMAL = 5'h01;
	localparam logic [4:0] SAMPLE_FIRST = 5'h0D;
	localparam logic [4:0] SAMPLE_AUTO = 5'h02;
	localparam logic [2:0] TRIG_SRC_DONE = 3'h0;
	localparam logic [2:0] SYNC_DEPTH = 3'h3;
	localparam logic [6:0] PRESCALE_MAX = 7'h7F;
	typedef enum logic [1:0] {
		ACS_IDLE,
		ACS_SYNC,
		ACS_ARMED,
		ACS_CONVERT
	} acs_state_t;
endpackage

// *** acs_prescaler.sv ***
// Converter clock prescaler producing a one-cycle rising-edge tick
`timescale 1ns/100ps
module acs_prescaler
	import acs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic restart,
	input wire logic [2:0] select,
	output logic tick
);
	typedef struct packed {
		logic [6:0] count;
		logic tick;
	} acs_pre_t;
	acs_pre_t st_reg, st_next;

	function automatic logic [6:0] div_limit(input logic [2:0] s);
		logic [7:0] d;
		d = 8'h01 << ((s == 3'h0) ? 3'h1 : s);
		return 7'(d - 8'h01);
	endfunction

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		// (RQ10) Held while disabled
		if (!enable || restart) begin
			st_next.count = '0;
		end else if (st_reg.count >= div_limit(select)) begin
			st_next.count = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.count = st_reg.count + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign tick = st_reg.tick;
endmodule

// *** acs_sequencer.sv ***
// Conversion start, timing and completion sequencer
// Notes on behaviour
// (RQ1) Start write launches conversion; bit held during it, cleared on completion.
// (RQ2) Channel change mid-conversion applies only after it ends.
// (RQ3) Selected trigger rising edge resets prescaler and starts conversion.
// (RQ4) Trigger still high or new edge during conversion starts nothing.
// (RQ5) Source flags set regardless of interrupt masking.
// (RQ6) Software clears the trigger source flag before next event.
// (RQ7) Done flag as trigger chains conversions; software starts the first.
// (RQ8) Free-running continues whether or not done flag is cleared.
// (RQ9) Start write works under auto trigger; start bit reads one always when busy.
// (RQ10) Prescaler runs while enabled, held reset while disabled.
// (RQ11) Software picks prescale for 50 kHz to 200 kHz clock.
// (RQ12) Start-bit conversion begins at next converter clock tick.
// (RQ13) Normal conversion 13 converter clocks, first after enable 25.
// (RQ14) Sample at 1.5 normal; first conversion sample taken at 13.5.
// (RQ15) Completion writes result, sets done flag, clears start bit together.
// (RQ16) Auto-triggered: sample 2 clocks after edge, three-cycle sync.
// (RQ17) Differential auto trigger not from done: every conversion 25 clocks.
// (RQ18) Free-running restarts immediately, start bit stays set.
// (RQ19) Differential user start: 13 if half-rate clock low, else 14.
// (RQ20) Differential free-running restarts take 14 clocks.
// (RQ21) Software toggles enable between differential auto conversions.
// (RQ22) Low byte read locks result until high byte read; flag still set.
// (RQ23) Channel and reference take effect only with enable set.
// (RQ24) Writing zero to start bit does nothing.
`timescale 1ns/100ps
module acs_sequencer
	import acs_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic CONVERTER_ENABLE,
	input wire logic AUTO_TRIGGER_ENABLE,
	input wire logic [2:0] TRIGGER_SOURCE_SELECT,
	input wire logic [2:0] CLOCK_PRESCALE_SELECT,
	input wire logic [7:0] TRIGGER_SOURCES,
	input wire logic START_WRITE,
	input wire logic START_WRITE_VALUE,
	input wire logic DONE_FLAG_CLEAR,
	input wire logic [4:0] CHANNEL_SELECT,
	input wire logic [1:0] REFERENCE_SELECT,
	input wire logic DIFFERENTIAL,
	input wire logic [9:0] CORE_RESULT,
	input wire logic RESULT_LOW_READ,
	input wire logic RESULT_HIGH_READ,
	output logic CONVERSION_START_BIT,
	output logic CONVERSION_DONE_FLAG,
	output logic BUSY,
	output logic SAMPLE_HOLD,
	output logic CORE_ENABLE,
	output logic [4:0] ACTIVE_CHANNEL,
	output logic [1:0] ACTIVE_REFERENCE,
	output logic [7:0] RESULT_LOW_BYTE,
	output logic [1:0] RESULT_HIGH_BYTE,
	output logic RESULT_LOST
);
	import acs_pkg::*;

	// All sequencer state; one comb copy, one registered copy
	typedef struct packed {
		acs_state_t state;
		logic busy;
		logic core_en;
		logic start_bit;
		logic done_flag;
		logic first_pending;
		logic auto_conv;
		logic [4:0] cycles;
		logic [4:0] length;
		logic [4:0] sample_at;
		logic [2:0] sync_cnt;
		logic trig_prev;
		logic half_clk;
		logic sample;
		logic locked;
		logic lost;
		logic [4:0] channel;
		logic [1:0] reference;
		logic [9:0] result;
	} acs_seq_t;

	acs_seq_t st_reg, st_next;
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic tick;
	logic trig_level;
	logic trig_rise;
	logic user_start;
	logic chain_start;
	logic finishing;
	logic pre_restart;

	// Release through two flip-flops
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Done flag is source 0; others come from on-chip flags
	assign trig_level = (TRIGGER_SOURCE_SELECT == TRIG_SRC_DONE) ? st_reg.done_flag
		: TRIGGER_SOURCES[TRIGGER_SOURCE_SELECT];
	// (RQ3) Edge detect on selected source
	assign trig_rise = trig_level && !st_reg.trig_prev;
	// (RQ24) Only a one-write starts
	assign user_start = START_WRITE && START_WRITE_VALUE && CONVERTER_ENABLE;
	// Last tick of the running conversion
	assign finishing = (st_reg.state == ACS_CONVERT) && tick && (st_reg.cycles == st_reg.length);
	// (RQ7) Completion acts as the rising edge of its own flag
	assign chain_start = finishing && AUTO_TRIGGER_ENABLE
		&& (TRIGGER_SOURCE_SELECT == TRIG_SRC_DONE);
	assign pre_restart = (st_reg.state == ACS_IDLE) && AUTO_TRIGGER_ENABLE && trig_rise
		&& (TRIGGER_SOURCE_SELECT != TRIG_SRC_DONE) && CONVERTER_ENABLE;

	acs_prescaler u_pre (
		.clk(CLK_SYS),
		.rst_n(rst_n),
		.enable(CONVERTER_ENABLE),
		.restart(pre_restart),
		.select(CLOCK_PRESCALE_SELECT),
		.tick(tick)
	);

	// Length in converter clocks of the conversion about to start
	function automatic logic [4:0] conv_len(input logic first, input logic diff, input logic half);
		if (first) begin
			return FIRST_CYCLES;
		end
		if (diff && half) begin
			return 5'(DIFF_SLOW_CYCLES);
		end
		return 5'(NORMAL_CYCLES);
	endfunction

	always_comb begin
		st_next = st_reg;
		st_next.sample = 1'b0;
		// Tracks always, so a level still high after a conversion gives no edge
		st_next.trig_prev = trig_level;
		if (tick) begin
			st_next.half_clk = !st_reg.half_clk;
		end
		// (RQ5) Done flag sets on every completion, set beats clear
		if (DONE_FLAG_CLEAR) begin
			st_next.done_flag = 1'b0;
		end
		// (RQ22) High byte read releases the lock
		if (RESULT_HIGH_READ) begin
			st_next.locked = 1'b0;
		end else if (RESULT_LOW_READ) begin
			st_next.locked = 1'b1;
		end
		// (RQ9) Start write accepted whatever the trigger mode
		if (user_start) begin
			st_next.start_bit = 1'b1;
		end
		unique case (st_reg.state)
			ACS_IDLE: begin
				// (RQ2) Selections track only between conversions
				if (CONVERTER_ENABLE) begin
					st_next.channel = CHANNEL_SELECT;
					st_next.reference = REFERENCE_SELECT;
				end
				if (pre_restart) begin
					// (RQ16) Synchronise before the auto conversion
					st_next.start_bit = 1'b1;
					st_next.auto_conv = 1'b1;
					st_next.sync_cnt = SYNC_DEPTH;
					st_next.state = ACS_SYNC;
				end else if (user_start || st_reg.start_bit) begin
					// (RQ12) Wait for next converter clock tick
					st_next.auto_conv = 1'b0;
					st_next.state = ACS_ARMED;
				end
			end
			ACS_SYNC: begin
				st_next.sync_cnt = st_reg.sync_cnt - 3'h1;
				if (st_reg.sync_cnt == 3'h1) begin
					st_next.state = ACS_ARMED;
				end
			end
			ACS_ARMED: begin
				if (tick) begin
					// (RQ13) First conversion after enable runs long
					// (RQ17) Differential auto-triggered one follows a re-enable
					// (RQ19) Half-rate phase picks 13 or 14
					st_next.length = conv_len(st_reg.first_pending, DIFFERENTIAL, st_reg.half_clk);
					// (RQ14) Sample instant; auto uses the fixed delay
					st_next.sample_at = st_reg.first_pending ? SAMPLE_FIRST
						: (st_reg.auto_conv ? SAMPLE_AUTO : SAMPLE_NORMAL);
					st_next.cycles = 5'h01;
					st_next.first_pending = 1'b0;
					st_next.state = ACS_CONVERT;
				end
			end
			ACS_CONVERT: begin
				if (tick) begin
					st_next.cycles = st_reg.cycles + 5'h01;
					if (st_reg.cycles == st_reg.sample_at) begin
						st_next.sample = 1'b1;
					end
				end
				// (RQ4) Trigger edges ignored while converting
				if (finishing) begin
					// (RQ15) Result, flag and start bit change together
					st_next.done_flag = 1'b1;
					st_next.lost = st_reg.locked;
					if (!st_reg.locked) begin
						st_next.result = CORE_RESULT;
					end
					if (chain_start) begin
						// (RQ18) Immediate restart, start bit kept
						// (RQ20) Half-rate clock high here, so 14 when differential
						// (RQ8) Independent of done flag clearing
						st_next.length = conv_len(1'b0, DIFFERENTIAL, 1'b1);
						st_next.sample_at = SAMPLE_NORMAL;
						st_next.cycles = 5'h01;
						st_next.half_clk = 1'b1;
						// (RQ2) Chained restart picks up a channel changed meanwhile
						if (CONVERTER_ENABLE) begin
							st_next.channel = CHANNEL_SELECT;
							st_next.reference = REFERENCE_SELECT;
						end
					end else begin
						// (RQ1) Hardware clears start bit
						st_next.start_bit = 1'b0;
						st_next.state = ACS_IDLE;
					end
				end
			end
		endcase
		// (RQ23) Disabled converter aborts and rearms the long first conversion
		if (!CONVERTER_ENABLE) begin
			st_next.state = ACS_IDLE;
			st_next.start_bit = 1'b0;
			st_next.first_pending = 1'b1;
			st_next.half_clk = 1'b0;
		end
		// Status outputs registered from the next state
		st_next.busy = st_next.state != ACS_IDLE;
		st_next.core_en = st_next.state == ACS_CONVERT;
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.state <= ACS_IDLE;
			st_reg.busy <= 1'b0;
			st_reg.core_en <= 1'b0;
			st_reg.start_bit <= 1'b0;
			st_reg.done_flag <= 1'b0;
			st_reg.first_pending <= 1'b1;
			st_reg.auto_conv <= 1'b0;
			st_reg.cycles <= 5'h00;
			st_reg.length <= 5'h00;
			st_reg.sample_at <= 5'h00;
			st_reg.sync_cnt <= 3'h0;
			st_reg.trig_prev <= 1'b0;
			st_reg.half_clk <= 1'b0;
			st_reg.sample <= 1'b0;
			st_reg.locked <= 1'b0;
			st_reg.lost <= 1'b0;
			st_reg.channel <= 5'h00;
			st_reg.reference <= 2'h0;
			st_reg.result <= 10'h000;
		end else begin
			st_reg.state <= st_next.state;
			st_reg.busy <= st_next.busy;
			st_reg.core_en <= st_next.core_en;
			st_reg.start_bit <= st_next.start_bit;
			st_reg.done_flag <= st_next.done_flag;
			st_reg.first_pending <= st_next.first_pending;
			st_reg.auto_conv <= st_next.auto_conv;
			st_reg.cycles <= st_next.cycles;
			st_reg.length <= st_next.length;
			st_reg.sample_at <= st_next.sample_at;
			st_reg.sync_cnt <= st_next.sync_cnt;
			st_reg.trig_prev <= st_next.trig_prev;
			st_reg.half_clk <= st_next.half_clk;
			st_reg.sample <= st_next.sample;
			st_reg.locked <= st_next.locked;
			st_reg.lost <= st_next.lost;
			st_reg.channel <= st_next.channel;
			st_reg.reference <= st_next.reference;
			st_reg.result <= st_next.result;
		end
	end

	// Every output is a plain register field
	assign CONVERSION_START_BIT = st_reg.start_bit;
	assign CONVERSION_DONE_FLAG = st_reg.done_flag;
	assign BUSY = st_reg.busy;
	assign SAMPLE_HOLD = st_reg.sample;
	assign CORE_ENABLE = st_reg.core_en;
	assign ACTIVE_CHANNEL = st_reg.channel;
	assign ACTIVE_REFERENCE = st_reg.reference;
	assign RESULT_LOW_BYTE = st_reg.result[7:0];
	assign RESULT_HIGH_BYTE = st_reg.result[9:8];
	assign RESULT_LOST = st_reg.lost;
endmodule

// *** acs_sva.sv ***
// Port assertions for the conversion sequencer
`timescale 1ns/100ps
module acs_sva
	import acs_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic CONVERTER_ENABLE,
	input wire logic AUTO_TRIGGER_ENABLE,
	input wire logic [2:0] TRIGGER_SOURCE_SELECT,
	input wire logic [7:0] TRIGGER_SOURCES,
	input wire logic START_WRITE,
	input wire logic START_WRITE_VALUE,
	input wire logic RESULT_LOW_READ,
	input wire logic RESULT_HIGH_READ,
	input wire logic CONVERSION_START_BIT,
	input wire logic CONVERSION_DONE_FLAG,
	input wire logic BUSY,
	input wire logic SAMPLE_HOLD,
	input wire logic CORE_ENABLE,
	input wire logic [4:0] ACTIVE_CHANNEL,
	input wire logic [7:0] RESULT_LOW_BYTE,
	input wire logic [1:0] RESULT_HIGH_BYTE
);
	logic lock_reg;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	// Mirrors the read lock; a simultaneous pair is never driven
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B)
			lock_reg <= 1'b0;
		else if (RESULT_LOW_READ)
			lock_reg <= 1'b1;
		else if (RESULT_HIGH_READ)
			lock_reg <= 1'b0;
	end
	sequence s_trig_rise;
		AUTO_TRIGGER_ENABLE && CONVERTER_ENABLE && !BUSY && TRIGGER_SOURCE_SELECT != TRIG_SRC_DONE
			&& $rose(TRIGGER_SOURCES[TRIGGER_SOURCE_SELECT]);
	endsequence
	sequence s_off2;
		!CONVERTER_ENABLE [*2];
	endsequence
	a_start_sets_bit: assert property (START_WRITE && START_WRITE_VALUE && CONVERTER_ENABLE && !BUSY
		|=> CONVERSION_START_BIT && BUSY) else $error("start write did not launch");
	a_bit_while_conv: assert property (CORE_ENABLE |-> CONVERSION_START_BIT)
		else $error("start bit low during conversion");
	a_fall_sets_done: assert property ($fell(CONVERSION_START_BIT) && $past(CONVERTER_ENABLE)
		|-> CONVERSION_DONE_FLAG) else $error("start bit cleared without done flag");
	a_trig_starts: assert property (s_trig_rise |-> ##[1:6] BUSY)
		else $error("trigger edge did not start");
	a_free_run_bit: assert property (AUTO_TRIGGER_ENABLE && TRIGGER_SOURCE_SELECT == TRIG_SRC_DONE
		&& CONVERTER_ENABLE && $rose(CONVERSION_DONE_FLAG) |-> CONVERSION_START_BIT)
		else $error("free running start bit dropped");
	a_off_idle: assert property (s_off2 |-> !CORE_ENABLE && !BUSY)
		else $error("activity while disabled");
	a_sample_due: assert property ($rose(CORE_ENABLE) |-> ##[0:60] SAMPLE_HOLD)
		else $error("no sample after start");
	a_chan_locked: assert property ($rose(CORE_ENABLE) && !AUTO_TRIGGER_ENABLE
		|=> $stable(ACTIVE_CHANNEL) [*8]) else $error("channel moved in conversion");
	a_result_lock: assert property (lock_reg && !RESULT_HIGH_READ
		|=> $stable({RESULT_HIGH_BYTE, RESULT_LOW_BYTE})) else $error("locked result changed");
endmodule
bind acs_sequencer acs_sva u_sva (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CONVERTER_ENABLE(CONVERTER_ENABLE),
	.AUTO_TRIGGER_ENABLE(AUTO_TRIGGER_ENABLE), .TRIGGER_SOURCE_SELECT(TRIGGER_SOURCE_SELECT),
	.TRIGGER_SOURCES(TRIGGER_SOURCES), .START_WRITE(START_WRITE), .START_WRITE_VALUE(START_WRITE_VALUE),
	.RESULT_LOW_READ(RESULT_LOW_READ), .RESULT_HIGH_READ(RESULT_HIGH_READ),
	.CONVERSION_START_BIT(CONVERSION_START_BIT), .CONVERSION_DONE_FLAG(CONVERSION_DONE_FLAG), .BUSY(BUSY),
	.SAMPLE_HOLD(SAMPLE_HOLD), .CORE_ENABLE(CORE_ENABLE), .ACTIVE_CHANNEL(ACTIVE_CHANNEL),
	.RESULT_LOW_BYTE(RESULT_LOW_BYTE), .RESULT_HIGH_BYTE(RESULT_HIGH_BYTE));

// *** acs_partner.sv ***
// Trigger event sources and analog core result model
`timescale 1ns/100ps
module acs_partner (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] event_pulse,
	input wire logic [7:0] flag_clear,
	input wire logic sample,
	output logic [7:0] flags,
	output logic [9:0] result
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= 8'h00;
			result <= 10'h2A5;
		end else begin
			// Flags set with no mask involved
			flags <= (flags & ~flag_clear) | event_pulse;
			// New value per sample so a lost result shows
			if (sample)
				result <= result + 10'h07B;
		end
	end
endmodule

// *** tb.sv ***
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module tb;
	import acs_pkg::*;
	typedef struct {logic [2:0] ps; logic df; logic first; logic zw; int tk;} acs_row_t;
	logic CLK_SYS, RST_B, CONVERTER_ENABLE, AUTO_TRIGGER_ENABLE, START_WRITE, START_WRITE_VALUE;
	logic DONE_FLAG_CLEAR, DIFFERENTIAL, RESULT_LOW_READ, RESULT_HIGH_READ, RESULT_LOST;
	logic CONVERSION_START_BIT, CONVERSION_DONE_FLAG, BUSY, SAMPLE_HOLD, CORE_ENABLE;
	logic [2:0] TRIGGER_SOURCE_SELECT, CLOCK_PRESCALE_SELECT;
	logic [7:0] TRIGGER_SOURCES, RESULT_LOW_BYTE, ev, fclr;
	logic [4:0] CHANNEL_SELECT, ACTIVE_CHANNEL;
	logic [1:0] REFERENCE_SELECT, ACTIVE_REFERENCE, RESULT_HIGH_BYTE;
	logic [9:0] CORE_RESULT, held;
	int fails, cmp_count, cyc, n, k, d;
	// Fast prescales keep the run short; resolution is not modelled
	acs_row_t rows[6] = '{'{3'h1, 1'b0, 1'b1, 1'b0, 25}, '{3'h1, 1'b0, 1'b0, 1'b0, 13},
		'{3'h0, 1'b0, 1'b0, 1'b0, 13}, '{3'h2, 1'b0, 1'b0, 1'b0, 13},
		'{3'h1, 1'b1, 1'b0, 1'b0, 13}, '{3'h2, 1'b0, 1'b0, 1'b1, 13}};
	acs_sequencer dut (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CONVERTER_ENABLE(CONVERTER_ENABLE),
		.AUTO_TRIGGER_ENABLE(AUTO_TRIGGER_ENABLE), .TRIGGER_SOURCE_SELECT(TRIGGER_SOURCE_SELECT),
		.CLOCK_PRESCALE_SELECT(CLOCK_PRESCALE_SELECT), .TRIGGER_SOURCES(TRIGGER_SOURCES),
		.START_WRITE(START_WRITE), .START_WRITE_VALUE(START_WRITE_VALUE), .DONE_FLAG_CLEAR(DONE_FLAG_CLEAR),
		.CHANNEL_SELECT(CHANNEL_SELECT), .REFERENCE_SELECT(REFERENCE_SELECT), .DIFFERENTIAL(DIFFERENTIAL),
		.CORE_RESULT(CORE_RESULT), .RESULT_LOW_READ(RESULT_LOW_READ), .RESULT_HIGH_READ(RESULT_HIGH_READ),
		.CONVERSION_START_BIT(CONVERSION_START_BIT), .CONVERSION_DONE_FLAG(CONVERSION_DONE_FLAG),
		.BUSY(BUSY), .SAMPLE_HOLD(SAMPLE_HOLD), .CORE_ENABLE(CORE_ENABLE), .ACTIVE_CHANNEL(ACTIVE_CHANNEL),
		.ACTIVE_REFERENCE(ACTIVE_REFERENCE), .RESULT_LOW_BYTE(RESULT_LOW_BYTE),
		.RESULT_HIGH_BYTE(RESULT_HIGH_BYTE), .RESULT_LOST(RESULT_LOST));
	acs_partner pm (.clk(CLK_SYS), .rst_n(RST_B), .event_pulse(ev), .flag_clear(fclr), .sample(SAMPLE_HOLD),
		.flags(TRIGGER_SOURCES), .result(CORE_RESULT));
	initial begin
		CLK_SYS = 1'b0;
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			test_done;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Clears the done flag, optionally writes start, waits for completion
	task automatic conv(input logic st, input logic zw);
		@(posedge CLK_SYS);
		DONE_FLAG_CLEAR <= 1'b1;
		START_WRITE <= st;
		START_WRITE_VALUE <= 1'b1;
		n = 0;
		while ((CONVERSION_DONE_FLAG !== 1'b1 || n < 2) && n < 400) begin
			@(posedge CLK_SYS);
			DONE_FLAG_CLEAR <= 1'b0;
			START_WRITE <= zw && n == 8;
			START_WRITE_VALUE <= 1'b0;
			if (zw && n == 8)
				CHANNEL_SELECT <= CHANNEL_SELECT + 5'h01;
			@(negedge CLK_SYS);
			n++;
		end
	endtask
	task automatic rd(input logic lo, input logic hi);
		@(posedge CLK_SYS);
		RESULT_LOW_READ <= lo;
		RESULT_HIGH_READ <= hi;
		@(posedge CLK_SYS);
		RESULT_LOW_READ <= 1'b0;
		RESULT_HIGH_READ <= 1'b0;
		@(negedge CLK_SYS);
	endtask
	// Re-arms the source flag, then raises it again
	task automatic evt;
		@(posedge CLK_SYS);
		// Flag cleared before the next event
		fclr <= 8'h04;
		@(posedge CLK_SYS);
		fclr <= 8'h00;
		ev <= 8'h04;
		@(posedge CLK_SYS);
		ev <= 8'h00;
		@(negedge CLK_SYS);
	endtask
	initial begin
		{RST_B, CONVERTER_ENABLE, AUTO_TRIGGER_ENABLE, START_WRITE, START_WRITE_VALUE, DONE_FLAG_CLEAR, DIFFERENTIAL,
			RESULT_LOW_READ, RESULT_HIGH_READ, TRIGGER_SOURCE_SELECT, CLOCK_PRESCALE_SELECT, CHANNEL_SELECT,
			REFERENCE_SELECT, ev, fclr} = '0;
		repeat (11) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
		chk({12'h0, CONVERSION_START_BIT, CONVERSION_DONE_FLAG, BUSY, CORE_ENABLE}, 16'h0);
		$display("reset test done");
		@(posedge CLK_SYS);
		RST_B <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		CONVERTER_ENABLE <= 1'b1;
		foreach (rows[i]) begin
			d = 1 << (rows[i].ps == 3'h0 ? 1 : rows[i].ps);
			@(posedge CLK_SYS);
			CLOCK_PRESCALE_SELECT <= rows[i].ps;
			DIFFERENTIAL <= rows[i].df;
			REFERENCE_SELECT <= rows[i].ps[1:0];
			// Enable dropped and raised on rows with first set, to rearm the long conversion
			CONVERTER_ENABLE <= !rows[i].first;
			repeat (2) @(posedge CLK_SYS);
			CONVERTER_ENABLE <= 1'b1;
			@(negedge CLK_SYS);
			chk({14'h0, ACTIVE_REFERENCE}, {14'h0, rows[i].first ? 2'h0 : rows[i].ps[1:0]});
			conv(1'b1, rows[i].zw);
			chk({15'h0, n >= (rows[i].tk - 1) * d + 1 && n <= (rows[i].tk + 2) * d + 4}, 16'h1);
			chk({6'h0, RESULT_HIGH_BYTE, RESULT_LOW_BYTE}, {6'h0, CORE_RESULT});
			chk({15'h0, CONVERSION_START_BIT}, 16'h0);
			repeat (2) @(negedge CLK_SYS);
			chk({11'h0, ACTIVE_CHANNEL}, {11'h0, CHANNEL_SELECT});
			chk({14'h0, ACTIVE_REFERENCE}, {14'h0, REFERENCE_SELECT});
			rd(1'b1, 1'b0);
			rd(1'b0, 1'b1);
			$display("row %0d done", i);
		end
		rd(1'b1, 1'b0);
		held = {RESULT_HIGH_BYTE, RESULT_LOW_BYTE};
		conv(1'b1, 1'b0);
		chk({6'h0, RESULT_HIGH_BYTE, RESULT_LOW_BYTE}, {6'h0, held});
		chk({14'h0, RESULT_LOST, CONVERSION_DONE_FLAG}, 16'h3);
		rd(1'b0, 1'b1);
		$display("lock test done");
		@(posedge CLK_SYS);
		AUTO_TRIGGER_ENABLE <= 1'b1;
		TRIGGER_SOURCE_SELECT <= 3'h2;
		repeat (2) begin
			evt;
			k = 0;
			while (BUSY !== 1'b1 && k < 10) begin
				@(negedge CLK_SYS);
				k++;
			end
			chk({15'h0, BUSY}, 16'h1);
			evt;
			conv(1'b0, 1'b0);
			k = 0;
			repeat (60) begin
				@(negedge CLK_SYS);
				if (BUSY !== 1'b0)
					k++;
			end
			chk(k[15:0], 16'h0);
		end
		$display("trigger test done");
		@(posedge CLK_SYS);
		TRIGGER_SOURCE_SELECT <= TRIG_SRC_DONE;
		conv(1'b1, 1'b0);
		@(posedge CLK_SYS);
		CHANNEL_SELECT <= CHANNEL_SELECT + 5'h03;
		n = 0;
		k = 0;
		repeat (200) begin
			@(negedge CLK_SYS);
			if (SAMPLE_HOLD === 1'b1)
				n++;
			if (CONVERSION_START_BIT !== 1'b1)
				k++;
		end
		chk({15'h0, n >= 3 && k == 0}, 16'h1);
		chk({11'h0, ACTIVE_CHANNEL}, {11'h0, CHANNEL_SELECT});
		@(posedge CLK_SYS);
		AUTO_TRIGGER_ENABLE <= 1'b0;
		conv(1'b0, 1'b0);
		chk({15'h0, CONVERSION_START_BIT}, 16'h0);
		$display("free running test done");
		test_done;
	end
endmodule
